/* File: rtl/swc_pkg.sv */
// Package: register map, fields, reset values and timing for the shutdown/wake controller
package swc_pkg;
  localparam logic [7:0] SWC_OFS_CMD = 8'h00;
  localparam logic [7:0] SWC_OFS_CFG = 8'h04;
  localparam logic [7:0] SWC_OFS_STAT = 8'h08;
  localparam logic [7:0] SWC_OFS_IMASK = 8'h0C;
  localparam logic [7:0] SWC_OFS_CTRL = 8'h10;
  localparam logic [7:0] SWC_KEY = 8'hA5;
  localparam int SWC_KEY_LSB = 24;
  localparam int SWC_OFF_BIT = 0;
  localparam int SWC_MODE_LSB = 0;
  localparam int SWC_CNT_LSB = 4;
  localparam int SWC_ALM_EN_BIT = 17;
  localparam int SWC_PIN_FLAG_BIT = 0;
  localparam int SWC_ALM_FLAG_BIT = 17;
  localparam logic [1:0] SWC_MODE_RST = 2'h3;
  localparam logic [3:0] SWC_CNT_RST = 4'h0;
  localparam logic [1:0] SWC_MODE_OFF = 2'h0;
  localparam logic [1:0] SWC_MODE_RISE = 2'h1;
  localparam logic [1:0] SWC_MODE_FALL = 2'h2;
  localparam logic [1:0] SWC_MODE_ANY = 2'h3;
  localparam int SWC_SLOW_HZ = 32768;
  localparam int SWC_CLK_HZ = 25000000;
  localparam int SWC_SLOW_DIV = SWC_CLK_HZ / SWC_SLOW_HZ;
  localparam int SWC_OFF_DELAY = 2;
  localparam int SWC_UNIT = 16;
  localparam logic [3:0] SWC_ACK_DELAY = 4'h0;
  typedef enum logic [2:0] {
    SWC_ST_RUN = 3'b001,
    SWC_ST_ARM = 3'b010,
    SWC_ST_OFF = 3'b100
  } swc_state_t;
endpackage

/* File: rtl/swc_debounce.sv */
// Wake pin transition detector and debounce counter
`timescale 1ns/100ps
module swc_debounce #(
  parameter int CNT_W = 4,
  parameter int UNIT = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic pin_i,
  input wire logic [1:0] mode_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic event_o
);
  localparam int TW = CNT_W + 8;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic run_r;
  logic [TW-1:0] cnt_r;
  wire logic rise = s2_r & ~s3_r;
  wire logic fall = ~s2_r & s3_r;
  wire logic chg = rise | fall;
  wire logic hit = (mode_i == swc_pkg::SWC_MODE_RISE && rise)
    || (mode_i == swc_pkg::SWC_MODE_FALL && fall)
    || (mode_i == swc_pkg::SWC_MODE_ANY && chg);
  wire logic [TW-1:0] target = TW'(count_i) * TW'(UNIT);
  wire logic done = run_r && (cnt_r >= target);

  // Synchroniser, counter and event pulse on slow ticks
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      run_r <= 1'b0;
      cnt_r <= '0;
      event_o <= 1'b0;
    end
    else
    begin
      event_o <= 1'b0;
      if (tick_i)
      begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (hit)
        begin
          run_r <= 1'b1;
          cnt_r <= '0;
        end
        else if (chg || mode_i == swc_pkg::SWC_MODE_OFF)
        begin
          run_r <= 1'b0;
          cnt_r <= '0;
        end
        else if (done)
        begin
          run_r <= 1'b0;
          event_o <= 1'b1;
        end
        else if (run_r)
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

/* File: rtl/swc_top.sv */
// Shutdown/wake controller top with classic Wishbone slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module swc_top #(
  parameter int SLOW_DIV = swc_pkg::SWC_SLOW_DIV
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wake_input_pin_i,
  input wire logic alarm_i,
  output logic power_off_output_o,
  output logic irq_o
);
  // ********************************
  // Slow clock tick divider
  // ********************************
  logic [15:0] div_r;
  logic tick_r;
  wire logic div_end = (div_r == 16'(SLOW_DIV - 1));

  // Free-running divider, never gated
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_end ? 16'h0000 : div_r + 16'h0001;
      tick_r <= div_end;
    end
  end

  // ********************************
  // Wishbone decode
  // ********************************
  // Byte lanes of the key, the low fields and the alarm fields
  localparam int LANE_W = 8;
  localparam int KEY_LANE = swc_pkg::SWC_KEY_LSB / LANE_W;
  localparam int LOW_LANE = swc_pkg::SWC_OFF_BIT / LANE_W;
  localparam int ALM_LANE = swc_pkg::SWC_ALM_EN_BIT / LANE_W;

  // Register state shared by decode and read-back
  logic [1:0] mode_r;
  logic [3:0] cnt_r;
  logic alm_en_r;
  logic pin_flag_r;
  logic alm_flag_r;
  logic [1:0] mask_r;
  logic [31:0] rdat;

  // Request qualification, once per bus cycle
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = req & wb_we_i;
  wire logic rd = req & ~wb_we_i;

  // Address decode
  wire logic sel_cmd = (wb_adr_i == swc_pkg::SWC_OFS_CMD);
  wire logic sel_cfg = (wb_adr_i == swc_pkg::SWC_OFS_CFG);
  wire logic sel_stat = (wb_adr_i == swc_pkg::SWC_OFS_STAT);
  wire logic sel_mask = (wb_adr_i == swc_pkg::SWC_OFS_IMASK);
  wire logic sel_ctrl = (wb_adr_i == swc_pkg::SWC_OFS_CTRL);

  // Keyed command and clear-on-read strobes
  wire logic key_ok = wb_sel_i[KEY_LANE]
    && (wb_dat_i[swc_pkg::SWC_KEY_LSB +: LANE_W] == swc_pkg::SWC_KEY);
  wire logic cmd_go = wr && sel_cmd && key_ok && wb_sel_i[LOW_LANE]
    && wb_dat_i[swc_pkg::SWC_OFF_BIT];
  wire logic stat_rd = rd && sel_stat;

  // Read-back words
  wire logic [31:0] cfg_word = {14'h0000, alm_en_r, 9'h000, cnt_r, 2'h0, mode_r};
  wire logic [31:0] stat_word = {14'h0000, alm_flag_r, 16'h0000, pin_flag_r};
  wire logic [31:0] mask_word = {14'h0000, mask_r[1], 16'h0000, mask_r[0]};
  wire logic [31:0] ctrl_word = {31'h00000000, power_off_output_o};

  // Read data select, unmapped reads as zero
  assign rdat = sel_cfg ? cfg_word :
                sel_stat ? stat_word :
                sel_mask ? mask_word :
                sel_ctrl ? ctrl_word : 32'h00000000;

  // Single-cycle acknowledge, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
    end
  end

  // Read data, stands only in the acknowledge cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_dat_o <= rd ? rdat : 32'h00000000;
    end
  end

  // Configuration writes, per byte lane
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_r <= swc_pkg::SWC_MODE_RST;
      cnt_r <= swc_pkg::SWC_CNT_RST;
      alm_en_r <= 1'b0;
    end
    else if (wr && sel_cfg)
    begin
      if (wb_sel_i[LOW_LANE])
      begin
        mode_r <= wb_dat_i[swc_pkg::SWC_MODE_LSB +: 2];
        cnt_r <= wb_dat_i[swc_pkg::SWC_CNT_LSB +: 4];
      end
      if (wb_sel_i[ALM_LANE])
        alm_en_r <= wb_dat_i[swc_pkg::SWC_ALM_EN_BIT];
    end
  end

  // Interrupt mask writes, same layout as status
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      mask_r <= 2'h0;
    else if (wr && sel_mask)
    begin
      if (wb_sel_i[LOW_LANE])
        mask_r[0] <= wb_dat_i[swc_pkg::SWC_PIN_FLAG_BIT];
      if (wb_sel_i[ALM_LANE])
        mask_r[1] <= wb_dat_i[swc_pkg::SWC_ALM_FLAG_BIT];
    end
  end

  // ********************************
  // Wake sources
  // ********************************
  logic pin_evt;
  logic a1_r;
  logic a2_r;
  logic a3_r;

  // Pin transition detector and debounce counter
  swc_debounce #(
    .CNT_W(4),
    .UNIT(swc_pkg::SWC_UNIT)
  ) u_deb (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick_r),
    .pin_i(wake_input_pin_i),
    .mode_i(mode_r),
    .count_i(cnt_r),
    .event_o(pin_evt)
  );

  // Alarm synchroniser on slow ticks
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      a1_r <= 1'b0;
      a2_r <= 1'b0;
      a3_r <= 1'b0;
    end
    else if (tick_r)
    begin
      a1_r <= alarm_i;
      a2_r <= a1_r;
      a3_r <= a2_r;
    end
  end

  // Alarm edge gated by its enable, merged wake request
  wire logic alm_evt = tick_r & a2_r & ~a3_r & alm_en_r;
  wire logic wake = pin_evt | alm_evt;

  // Sticky flags, set wins over read clear
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_flag_r <= 1'b0;
      alm_flag_r <= 1'b0;
    end
    else
    begin
      pin_flag_r <= pin_evt | (pin_flag_r & ~stat_rd);
      alm_flag_r <= alm_evt | (alm_flag_r & ~stat_rd);
    end
  end

  // ********************************
  // Power-off sequencer
  // ********************************
  // Sequencer state, arming delay and next output level
  swc_pkg::swc_state_t state_r;
  swc_pkg::swc_state_t state_nxt;
  logic [1:0] dly_r;
  logic [1:0] dly_nxt;
  logic off_nxt;

  // Next state: arm, count two ticks, hold until wake
  always_comb
  begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    off_nxt = power_off_output_o;
    case (state_r)
      swc_pkg::SWC_ST_RUN:
      begin
        if (cmd_go)
        begin
          state_nxt = swc_pkg::SWC_ST_ARM;
          dly_nxt = 2'h0;
        end
      end
      swc_pkg::SWC_ST_ARM:
      begin
        if (tick_r)
        begin
          dly_nxt = dly_r + 2'h1;
          if (dly_r == 2'(swc_pkg::SWC_OFF_DELAY - 1))
          begin
            state_nxt = swc_pkg::SWC_ST_OFF;
            off_nxt = 1'b1;
          end
        end
      end
      swc_pkg::SWC_ST_OFF:
      begin
        if (wake)
        begin
          state_nxt = swc_pkg::SWC_ST_RUN;
          off_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt = swc_pkg::SWC_ST_RUN;
        off_nxt = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= swc_pkg::SWC_ST_RUN;
      dly_r <= 2'h0;
      power_off_output_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      power_off_output_o <= off_nxt;
    end
  end

  // ********************************
  // Interrupt output
  // ********************************
  wire logic irq_nxt = (pin_flag_r & mask_r[0]) | (alm_flag_r & mask_r[1]);

  // Level interrupt, one clock behind the flags
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_nxt;
  end
endmodule

/* File: verif/swc_chk.sv */
// Checker: port-level timing of the shutdown/wake controller
`timescale 1ns/100ps
module swc_chk #(
  parameter int SLOW_DIV = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wake_input_pin_i,
  input wire logic alarm_i,
  input wire logic power_off_output_o,
  input wire logic irq_o
);
  localparam int AW = 4 * SLOW_DIV;
  localparam int PQ = 250 * SLOW_DIV;
  logic [11:0] since_r;
  logic [11:0] aq_r;
  logic [11:0] pq_r;
  logic en_r;
  // Bus access decode at the acknowledge edge
  wire acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  wire wr = acc && wb_we_i;
  wire rd_stat = acc && !wb_we_i && wb_adr_i == swc_pkg::SWC_OFS_STAT;
  wire keyed = wr && wb_adr_i == swc_pkg::SWC_OFS_CMD && wb_dat_i[31:24] == swc_pkg::SWC_KEY
    && wb_dat_i[0] && wb_sel_i[3] && wb_sel_i[0];
  // Cycles since command, alarm rise and pin change
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      since_r <= 12'hFFF;
      aq_r <= 12'hFFF;
      pq_r <= 12'hFFF;
      en_r <= 1'b0;
    end
    else
    begin
      since_r <= (keyed && since_r > AW) ? 12'h000 : since_r + {11'h000, ~&since_r};
      aq_r <= $rose(alarm_i) ? 12'h000 : aq_r + {11'h000, ~&aq_r};
      pq_r <= $changed(wake_input_pin_i) ? 12'h000 : pq_r + {11'h000, ~&pq_r};
      if (wr && wb_adr_i == swc_pkg::SWC_OFS_CFG && wb_sel_i[2])
        en_r <= wb_dat_i[17];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Two status reads back to back with no wake activity
  sequence s_rd2;
    rd_stat ##3 (rd_stat && aq_r > AW && pq_r > PQ);
  endsequence
  chk_cmd_delay: assert property ($rose(power_off_output_o)
    |-> since_r >= SLOW_DIV - 1 && since_r <= 2 * SLOW_DIV + 2) else $error("bad off delay");
  chk_alarm_wake: assert property (power_off_output_o && en_r && $rose(alarm_i)
    |-> ##[1:AW] !power_off_output_o) else $error("alarm ignored");
  chk_wake_cause: assert property ($fell(power_off_output_o)
    |-> pq_r <= PQ || en_r && aq_r <= AW) else $error("release without wake");
  chk_irq_clear: assert property (rd_stat && aq_r > AW && pq_r > PQ |-> ##2 !irq_o)
    else $error("irq kept after read");
  chk_read_twice: assert property (s_rd2 |-> wb_dat_o[17] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("flag kept after read");
  chk_stat_bits: assert property (rd_stat |-> (wb_dat_o & 32'hFFFD_FFFE) == 32'h0)
    else $error("stray status bit");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
endmodule

/* File: verif/swc_wake_src.sv */
// Wake sources model: push-button pin and clock alarm
`timescale 1ns/100ps
module swc_wake_src (
  input wire logic clk_i,
  output logic pin_o,
  output logic alarm_o
);
  initial
  begin
    pin_o = 1'b0;
    alarm_o = 1'b0;
  end
  // Pin level change just after an edge
  task automatic set_pin(input logic v);
    begin
      @(posedge clk_i);
      pin_o <= v;
    end
  endtask
  // Alarm pulse of three slow ticks
  task automatic ring();
    begin
      @(posedge clk_i);
      alarm_o <= 1'b1;
      repeat (12) @(posedge clk_i);
      alarm_o <= 1'b0;
    end
  endtask
endmodule

/* File: verif/test_shutdown_wakeup_controller.sv */
// Bench: bus tasks and wake scenarios for the shutdown controller
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module test_shutdown_wakeup_controller;
  localparam int D = 4;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o, pin, alarm, po, irq_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int k;
  always #20 clk_i = ~clk_i;
  swc_top #(.SLOW_DIV(D)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wake_input_pin_i(pin), .alarm_i(alarm), .power_off_output_o(po), .irq_o(irq_o));
  swc_wake_src src (.clk_i(clk_i), .pin_o(pin), .alarm_o(alarm));
  // ****************
  // Tasks
  // ****************
  task automatic summarize();
    begin
      $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
        @(posedge clk_i);
        n++;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
        n_mismatch++;
        summarize();
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
    end
  endtask
  // Bounded wait for the power-off level
  task automatic wait_po(input logic v);
    begin
      k = 0;
      while (po !== v && k < 2000)
      begin
        @(posedge clk_i);
        k++;
      end
      `CHK(po, v)
      if (po !== v)
        summarize();
    end
  endtask
  task automatic settle(input logic v);
    begin
      repeat (40 * D) @(posedge clk_i);
      `CHK(po, v)
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h04, 32'h3);
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, 8'h00, 32'h5A000001);
    settle(1'b0);
    wb(1'b1, 8'h00, 32'hA5000000);
    settle(1'b0);
    wb(1'b1, 8'h0C, 32'h00020001);
    rd(8'h0C, 32'h00020001);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, 8'h04, m);
      wb(1'b1, 8'h00, 32'hA5000001);
      wait_po(1'b1);
      src.set_pin(1'b1);
      settle(!m[0]);
      src.set_pin(1'b0);
      settle(m == 0);
    end
    wb(1'b1, 8'h04, 32'h11);
    rd(8'h04, 32'h11);
    wb(1'b1, 8'h00, 32'hA5000001);
    wait_po(1'b1);
    rd(8'h10, 32'h1);
    src.set_pin(1'b1);
    repeat (5 * D) @(posedge clk_i);
    src.set_pin(1'b0);
    settle(1'b1);
    src.set_pin(1'b1);
    wait_po(1'b0);
    `CHK(k inside {[16 * D:21 * D]}, 1'b1)
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rd(8'h08, 32'h1);
    rd(8'h08, 32'h0);
    `CHK(irq_o, 1'b0)
    wb(1'b1, 8'h00, 32'hA5000001);
    wait_po(1'b1);
    src.ring();
    settle(1'b1);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h04, 32'h00020011);
    rd(8'h04, 32'h00020011);
    src.ring();
    wait_po(1'b0);
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rd(8'h08, 32'h00020000);
    repeat (1100) @(posedge clk_i);
    rd(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    summarize();
  end
endmodule
bind swc_top swc_chk #(.SLOW_DIV(SLOW_DIV)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wake_input_pin_i(wake_input_pin_i), .alarm_i(alarm_i),
  .power_off_output_o(power_off_output_o), .irq_o(irq_o));
